// ==== sag_arm_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module sag_arm_link_model (
    input wire logic i_dout,
    output logic o_din,
    output logic o_sel,
    output logic o_sclk,
    output logic o_pin67
);
    initial begin
        {o_din, o_sel, o_sclk, o_pin67} = 4'h0;
    end

    // Pin changes keep clear of the bench clock edges so the sampling never races.
    task automatic set_pins(input logic [3:0] lv);
        #2 {o_din, o_sel, o_sclk, o_pin67} = lv;
    endtask

    // A frame of e edges carries e+1 bits; bit e goes out first at select rise.
    task automatic send(input logic [7:0] bits, input int e, output logic dout_seen);
        #2 o_din = bits[e];
        #40 o_sel = 1'b1;
        for (int k = e - 1; k >= 0; k--) begin
            #20 o_din = bits[k];
            #20 o_sclk = ~o_sclk;
        end
        #200 dout_seen = i_dout;
        o_sel = 1'b0;
        // The released data line flips so a stale level is never mistaken for data.
        #20 o_din = ~o_din;
        o_sclk = 1'b0;
    endtask
endmodule // sag_arm_link_model

`default_nettype wire

// ==== sag_channel.sv ====
`timescale 1ns/10ps
`default_nettype none

module sag_channel #(
    parameter int unsigned STRETCH_CYC = 1000000,
    parameter int unsigned FIRE_CYC = 200000
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_arm_hold,
    input wire logic i_arm_start,
    input wire logic i_deploy,
    input wire logic i_idle,
    input wire logic i_permit,
    input wire logic i_gnd_loss,
    input wire logic i_diag_drive,
    output logic o_window,
    output logic o_firing,
    output logic o_high_side_switch,
    output logic o_low_side_switch
);
    localparam int SW = $clog2(STRETCH_CYC + 1);
    localparam int FW = $clog2(FIRE_CYC + 1);

    typedef struct packed {
        logic arm_run;
        logic [SW-1:0] arm_cnt;
        logic spi_run;
        logic [SW-1:0] spi_cnt;
        logic firing;
        logic [FW-1:0] fire_cnt;
        logic sw;
    } sag_ch_state_t;

    sag_ch_state_t q;
    sag_ch_state_t d;
    logic arm_win;
    logic ok;

    always_comb begin
        d = q;
        // The start pulse bridges the cycle between a dropped hold and a running timer.
        arm_win = i_arm_hold | i_arm_start | q.arm_run;
        ok = i_permit & ~i_gnd_loss;
        if (q.arm_run) begin
            d.arm_cnt = q.arm_cnt - SW'(1);
            if (q.arm_cnt == SW'(1)) begin
                d.arm_run = 1'b0;
            end
        end
        if (i_arm_start) begin
            d.arm_run = 1'b1;
            d.arm_cnt = SW'(STRETCH_CYC);
        end
        if (q.spi_run) begin
            d.spi_cnt = q.spi_cnt - SW'(1);
            if (q.spi_cnt == SW'(1)) begin
                d.spi_run = 1'b0;
            end
        end
        if (q.firing) begin
            // Firing runs out its time whatever arrives meanwhile.
            d.fire_cnt = q.fire_cnt - FW'(1);
            if (q.fire_cnt == FW'(1)) begin
                d.firing = 1'b0;
            end
        end else begin
            // Commands reach the timers only while the channel is not firing.
            if (i_deploy && ok && !q.spi_run) begin
                d.spi_run = 1'b1;
                d.spi_cnt = SW'(STRETCH_CYC);
            end
            if (i_idle) begin
                d.spi_run = 1'b0;
            end
            if (ok && arm_win && (q.spi_run || i_deploy)) begin
                d.firing = 1'b1;
                d.fire_cnt = FW'(FIRE_CYC);
                d.spi_run = 1'b0;
            end
        end
        d.sw = (d.firing | i_diag_drive) & i_permit;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_window = i_arm_hold | i_arm_start | q.arm_run | q.spi_run;
    assign o_firing = q.firing;
    assign o_high_side_switch = q.sw;
    assign o_low_side_switch = q.sw;

endmodule // sag_channel

`default_nettype wire

// ==== sag_defines.svh ====
`ifndef SAG_DEFINES_SVH
`define SAG_DEFINES_SVH

// Reference clock rate in MHz, used to turn times into cycle counts.
`define SAG_CLK_MHZ 100

// Times in microseconds.
`define SAG_DEGLITCH_US 10
`define SAG_STRETCH_US 10000
`define SAG_FIRE_US 2000
`define SAG_DIAG_STEP_US 2500

// Command word fields.
`define SAG_MODE_HI 15
`define SAG_MODE_LO 14
`define SAG_BIT_D12 12
`define SAG_BIT_D9 9
`define SAG_BIT_D8 8
`define SAG_LOW_BYTE_HI 7

// Mode codes carried in the two top command bits.
`define SAG_MODE_MONITOR 2'h3
`define SAG_MODE_DIAG 2'h2
`define SAG_MODE_REGISTER 2'h1
`define SAG_MODE_COMMAND 2'h0
`define SAG_MODE_RESET 2'h3

// Serial arming word and message check.
`define SAG_SER_BITS 4
`define SAG_SER_EDGES_OK 2'h3

`endif

// ==== sag_pkg.sv ====
package sag_pkg;

    typedef enum logic [1:0] {
        SAG_DG_IDLE,
        SAG_DG_TEST,
        SAG_DG_NEXT
    } sag_diag_state_t;

    typedef enum logic [1:0] {
        SAG_DT_BATT,
        SAG_DT_OPEN,
        SAG_DT_RES,
        SAG_DT_MOS
    } sag_diag_test_t;

endpackage

// ==== sag_properties.sv ====
`timescale 1ns/10ps
`default_nettype none

module sag_properties #(
    parameter int unsigned FIRE_CYC = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_enable_in_ch23,
    input wire logic i_serial_mode,
    input wire logic i_fire_permit,
    input wire logic i_cmd_valid,
    input wire logic [15:0] i_cmd_word,
    input wire logic i_diag_start,
    input wire logic o_serial_enable_dout,
    input wire logic o_serial_enable_dout_oe_n,
    input wire logic [1:0] o_mode,
    input wire logic o_sbl_active,
    input wire logic o_diag_busy,
    input wire logic [7:0] o_window,
    input wire logic [7:0] o_firing,
    input wire logic [7:0] o_high_side_switch,
    input wire logic [7:0] o_low_side_switch
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    logic [15:0] w;
    assign w = i_cmd_word;

    // Switches follow firing in the same cycle; a diagnostic drive shows one cycle late.
    switch_cause_a: assert property ((o_high_side_switch & ~o_firing) == 8'h00
        || o_diag_busy || $past(o_diag_busy)) else $error("switch on without cause");
    switch_pair_a: assert property (o_high_side_switch == o_low_side_switch)
        else $error("high and low switch differ");
    for (genvar c = 0; c < 8; c++) begin : g_ch
        fire_length_a: assert property ($fell(o_firing[c]) |-> $past(o_firing[c], FIRE_CYC))
            else $error("firing ended early");
        fire_window_a: assert property ($rose(o_firing[c]) |-> $past(o_window[c]))
            else $error("firing outside window");
    end
    permit_block_a: assert property (!i_fire_permit [*4] |-> o_high_side_switch == 8'h00)
        else $error("switch on with permit low");
    dout_idle_a: assert property ((i_serial_mode && !i_enable_in_ch23) [*4] |-> !o_serial_enable_dout)
        else $error("serial out not low while deselected");
    oe_mode_a: assert property (o_serial_enable_dout_oe_n == !i_serial_mode)
        else $error("serial out enable wrong");
    mode_load_a: assert property (i_cmd_valid |=> o_mode == $past(w[15:14]))
        else $error("mode not loaded");
    sbl_start_a: assert property (i_cmd_valid && w[12] && w[9] && (w[15:14] == 2'h2
        || (w[15:14] == 2'h3 && w[8])) |=> o_sbl_active) else $error("loop test not started");
    sbl_stop_a: assert property (i_cmd_valid && ((w[15:14] == 2'h3 && w[12] && w[9] && !w[8])
        || (w[15:14] == 2'h2 && w[12] && !w[9]) || (w[15:14] == 2'h0 && w[7:0] == 8'h00))
        |=> !o_sbl_active) else $error("loop test not stopped");
    sbl_cause_a: assert property ($rose(o_sbl_active) |-> $past(i_cmd_valid))
        else $error("loop test started by itself");
    diag_cause_a: assert property ($rose(o_diag_busy) |-> $past(i_diag_start))
        else $error("diagnostic started by itself");

    cover property ($rose(o_firing[0]) || $rose(o_firing[6]));
    cover property ($fell(o_sbl_active));
    cover property ($fell(o_diag_busy));
endmodule // sag_properties

bind sag_top sag_properties #(.FIRE_CYC(FIRE_CYC)) u_props (.*);

`default_nettype wire

// ==== sag_top.sv ====
// Functional notes
// - Each channel has two stretch timers, one started by its enable input, one by SPI deploy.
// - SPI deploy starts the timer at chip select fall; repeats never restart it.
// - Idle cancels only SPI-started timers; enable-started timers keep running.
// - SPI-started window fires only inside an enable window (enable high or its countdown running); firing cannot be aborted.
// - A firing channel ignores all commands; other channels work normally.
// - Discrete enable: window after deglitch high; countdown deglitch after fall.
// - Enable-armed window fires on SPI deploy inside it or an already running SPI timer; firing completes.
// - Serial: arm state captured at select release; timer starts deglitch later.
// - Serial arming mode is selected by the configuration bit, else discrete.
// - Discrete pins arm pairs 0/1..6/7; serial uses them as din, select, clk, dout.
// - Serial word is four bits MSB first; first bit is pair 0/1, last 6/7.
// - With select high, shift on both clock edges; clock ignored with select low.
// - On select fall, copy shift register to arm latch then clear it.
// - Accept a serial message only when its edge count is 4n-1.
// - Serial data out low without select; else shift register MSB first.
// - Fire permit low blocks switches and deploys; never stops a running firing.
// - Diagnostics run with permit low; switch test then reports low-side fault.
// - Reset enters monitor mode (top bits 11); diagnostics only on command.
// - A diagnostic fault flags the channel, skips its other tests, moves on.
// - Short-between-loops test starts on the two documented start commands.
// - It stops on the three documented stop commands; others leave it running.
// - After reset the short-between-loops test is off until commanded.
// - Loop switches turn on only for firing or a switch diagnostic.
// - Ground loss blocks new diagnostics and firings on that channel only.
`include "sag_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module sag_top #(
    parameter int unsigned DEGLITCH_CYC = `SAG_DEGLITCH_US * `SAG_CLK_MHZ,
    parameter int unsigned STRETCH_CYC = `SAG_STRETCH_US * `SAG_CLK_MHZ,
    parameter int unsigned FIRE_CYC = `SAG_FIRE_US * `SAG_CLK_MHZ,
    parameter int unsigned DIAG_STEP_CYC = `SAG_DIAG_STEP_US * `SAG_CLK_MHZ
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Shared arming pins; in serial mode ch01 is data in, ch23 select, ch45 clock.
    input wire logic i_enable_in_ch01,
    input wire logic i_enable_in_ch23,
    input wire logic i_enable_in_ch45,
    input wire logic i_enable_in_ch67,
    output logic o_serial_enable_dout,
    output logic o_serial_enable_dout_oe_n,
    input wire logic i_serial_mode,
    input wire logic i_fire_permit,
    input wire logic [7:0] i_gnd_loss,
    input wire logic i_cmd_valid,
    input wire logic [15:0] i_cmd_word,
    input wire logic i_deploy_valid,
    input wire logic [7:0] i_deploy_ch,
    input wire logic i_idle_valid,
    input wire logic [7:0] i_idle_ch,
    input wire logic i_diag_start,
    input wire logic i_diag_mos_en,
    input wire logic i_diag_fault,
    input wire logic i_mos_ok,
    input wire logic i_fault_clear,
    output logic [1:0] o_mode,
    output logic o_sbl_active,
    output logic o_diag_busy,
    output logic [2:0] o_diag_ch,
    output sag_pkg::sag_diag_test_t o_diag_test,
    output logic [7:0] o_fault,
    output logic [7:0] o_ls_fault,
    output logic [7:0] o_window,
    output logic [7:0] o_firing,
    output logic [7:0] o_high_side_switch,
    output logic [7:0] o_low_side_switch
);
    import sag_pkg::*;

    localparam int DGW = $clog2(DEGLITCH_CYC + 1);
    localparam int DSW = $clog2(DIAG_STEP_CYC + 1);
    localparam int PERMIT = 4;

    if (DEGLITCH_CYC < 1 || STRETCH_CYC < 1 || FIRE_CYC < 1 || DIAG_STEP_CYC < 1) begin : g_bad
        $error("sag_top: every time count must be at least one cycle");
    end

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [3:0] filt;
        logic [3:0][DGW-1:0] dg_cnt;
        logic [`SAG_SER_BITS-1:0] sr;
        logic [1:0] edges;
        logic [`SAG_SER_BITS-1:0] armed;
        logic sdly_run;
        logic [DGW-1:0] sdly_cnt;
        logic [7:0] arm_start;
        logic dout;
        logic [1:0] mode;
        logic sbl;
        sag_diag_state_t dstate;
        sag_diag_test_t dtest;
        logic [2:0] dch;
        logic [DSW-1:0] dcnt;
        logic mos_en;
        logic [7:0] fault;
        logic [7:0] ls_fault;
        logic [7:0] drive;
    } sag_top_state_t;

    sag_top_state_t q;
    sag_top_state_t d;
    logic [4:0] pins;
    logic [7:0] firing_w;
    logic [7:0] arm_hold;
    logic sel;
    logic sel_rise;
    logic sel_fall;
    logic clk_edge;
    logic permit;
    logic skip;
    logic [1:0] mode_in;
    logic sbl_start;
    logic sbl_stop;

    assign pins = {i_fire_permit, i_enable_in_ch67, i_enable_in_ch45,
                   i_enable_in_ch23, i_enable_in_ch01};
    assign permit = q.s2[PERMIT];
    assign sel = q.s2[1];
    assign sel_rise = q.s2[1] & ~q.s3[1];
    assign sel_fall = ~q.s2[1] & q.s3[1];
    assign clk_edge = q.s2[2] ^ q.s3[2];
    assign mode_in = i_cmd_word[`SAG_MODE_HI:`SAG_MODE_LO];

    // Short-between-loops start and stop decode; the two sets never overlap.
    always_comb begin
        sbl_start = 1'b0;
        sbl_stop = 1'b0;
        case (mode_in)
            `SAG_MODE_MONITOR: begin
                sbl_start = i_cmd_word[`SAG_BIT_D12] & i_cmd_word[`SAG_BIT_D9]
                            & i_cmd_word[`SAG_BIT_D8];
                sbl_stop = i_cmd_word[`SAG_BIT_D12] & i_cmd_word[`SAG_BIT_D9]
                           & ~i_cmd_word[`SAG_BIT_D8];
            end
            `SAG_MODE_DIAG: begin
                sbl_start = i_cmd_word[`SAG_BIT_D12] & i_cmd_word[`SAG_BIT_D9];
                sbl_stop = i_cmd_word[`SAG_BIT_D12] & ~i_cmd_word[`SAG_BIT_D9];
            end
            `SAG_MODE_COMMAND: begin
                sbl_stop = (i_cmd_word[`SAG_LOW_BYTE_HI:0] == 8'h00);
            end
            default: begin
                sbl_start = 1'b0;
            end
        endcase
    end

    always_comb begin
        d = q;
        // The first stage feeds only the second; edges compare stage two with three.
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.arm_start = 8'h00;
        skip = 1'b0;

        // Discrete arming: a symmetric deglitch filter per pin pair.
        for (int p = 0; p < 4; p++) begin
            if (i_serial_mode || q.s2[p] == q.filt[p]) begin
                d.dg_cnt[p] = '0;
            end else if (q.dg_cnt[p] == DGW'(DEGLITCH_CYC - 1)) begin
                d.dg_cnt[p] = '0;
                d.filt[p] = q.s2[p];
                if (q.filt[p]) begin
                    // Countdown starts one deglitch time after the pin fell.
                    d.arm_start[2*p] = 1'b1;
                    d.arm_start[2*p+1] = 1'b1;
                end
            end else begin
                d.dg_cnt[p] = q.dg_cnt[p] + DGW'(1);
            end
        end
        if (i_serial_mode) begin
            d.filt = 4'h0;
        end

        // Serial arming link.
        if (!i_serial_mode) begin
            d.sr = '0;
            d.edges = 2'h0;
            d.sdly_run = 1'b0;
        end else begin
            if (sel_rise) begin
                // The bit present at select rise is the first one taken.
                d.sr = {q.sr[`SAG_SER_BITS-2:0], q.s2[0]};
                d.edges = 2'h0;
            end else if (sel && clk_edge) begin
                d.sr = {q.sr[`SAG_SER_BITS-2:0], q.s2[0]};
                d.edges = q.edges + 2'h1;
            end
            if (sel_fall) begin
                // Only the low two bits matter: 4n-1 edges means count mod 4 is 3.
                if (q.edges == `SAG_SER_EDGES_OK) begin
                    d.armed = q.sr;
                    d.sdly_run = 1'b1;
                    d.sdly_cnt = DGW'(DEGLITCH_CYC);
                end
                d.sr = '0;
                d.edges = 2'h0;
            end
            if (q.sdly_run) begin
                d.sdly_cnt = q.sdly_cnt - DGW'(1);
                if (q.sdly_cnt == DGW'(1)) begin
                    d.sdly_run = 1'b0;
                    for (int c = 0; c < 8; c++) begin
                        d.arm_start[c] = q.armed[3 - c/2];
                    end
                end
            end
        end
        d.dout = i_serial_mode & sel & d.sr[`SAG_SER_BITS-1];

        // Mode and short-between-loops test.
        if (i_cmd_valid) begin
            d.mode = mode_in;
            if (sbl_start) begin
                d.sbl = 1'b1;
            end else if (sbl_stop) begin
                d.sbl = 1'b0;
            end
        end

        // Diagnostic sequencer; clears come first so that a fault set wins.
        if (i_fault_clear) begin
            d.fault = 8'h00;
            d.ls_fault = 8'h00;
        end
        d.drive = 8'h00;
        case (q.dstate)
            SAG_DG_IDLE: begin
                if (i_diag_start) begin
                    d.dstate = SAG_DG_TEST;
                    d.dch = 3'h0;
                    d.dtest = SAG_DT_BATT;
                    d.dcnt = DSW'(DIAG_STEP_CYC);
                    d.mos_en = i_diag_mos_en;
                end
            end
            SAG_DG_TEST: begin
                skip = i_gnd_loss[q.dch] | firing_w[q.dch];
                d.dcnt = q.dcnt - DSW'(1);
                if (skip) begin
                    d.dstate = SAG_DG_NEXT;
                end else if (i_diag_fault) begin
                    d.fault[q.dch] = 1'b1;
                    d.dstate = SAG_DG_NEXT;
                end else if (q.dtest == SAG_DT_MOS && i_mos_ok && permit) begin
                    d.dstate = SAG_DG_NEXT;
                end else if (q.dcnt == DSW'(1)) begin
                    d.dcnt = DSW'(DIAG_STEP_CYC);
                    case (q.dtest)
                        SAG_DT_BATT: d.dtest = SAG_DT_OPEN;
                        SAG_DT_OPEN: d.dtest = SAG_DT_RES;
                        SAG_DT_RES: begin
                            if (q.mos_en) begin
                                d.dtest = SAG_DT_MOS;
                            end else begin
                                d.dstate = SAG_DG_NEXT;
                            end
                        end
                        default: begin
                            // Switches blocked by the permit never see the loop respond.
                            d.fault[q.dch] = 1'b1;
                            d.ls_fault[q.dch] = 1'b1;
                            d.dstate = SAG_DG_NEXT;
                        end
                    endcase
                end
                if (d.dstate == SAG_DG_TEST && d.dtest == SAG_DT_MOS) begin
                    d.drive[d.dch] = 1'b1;
                end
            end
            SAG_DG_NEXT: begin
                if (q.dch == 3'h7) begin
                    d.dstate = SAG_DG_IDLE;
                end else begin
                    d.dch = q.dch + 3'h1;
                    d.dtest = SAG_DT_BATT;
                    d.dcnt = DSW'(DIAG_STEP_CYC);
                    d.dstate = SAG_DG_TEST;
                end
            end
            default: begin
                d.dstate = SAG_DG_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.mode <= `SAG_MODE_RESET;
            q.sbl <= 1'b0;
            q.dstate <= SAG_DG_IDLE;
            q.dtest <= SAG_DT_BATT;
        end else begin
            q <= d;
        end
    end

    // Discrete windows hold while a filtered pin is high; serial arming has no hold.
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            arm_hold[c] = ~i_serial_mode & q.filt[c/2];
        end
    end

    for (genvar c = 0; c < 8; c++) begin : g_ch
        sag_channel #(
            .STRETCH_CYC(STRETCH_CYC),
            .FIRE_CYC(FIRE_CYC)
        ) u_ch (
            .i_ref_clk(i_ref_clk),
            .i_rstn(i_rstn),
            .i_arm_hold(arm_hold[c]),
            .i_arm_start(q.arm_start[c]),
            .i_deploy(i_deploy_valid & i_deploy_ch[c]),
            .i_idle(i_idle_valid & i_idle_ch[c]),
            .i_permit(permit),
            .i_gnd_loss(i_gnd_loss[c]),
            .i_diag_drive(q.drive[c]),
            .o_window(o_window[c]),
            .o_firing(firing_w[c]),
            .o_high_side_switch(o_high_side_switch[c]),
            .o_low_side_switch(o_low_side_switch[c])
        );
    end

    // The pin is driven only in serial mode; low outside select.
    assign o_serial_enable_dout = q.dout;
    assign o_serial_enable_dout_oe_n = ~i_serial_mode;
    assign o_firing = firing_w;
    assign o_mode = q.mode;
    assign o_sbl_active = q.sbl;
    assign o_diag_busy = (q.dstate != SAG_DG_IDLE);
    assign o_diag_ch = q.dch;
    assign o_diag_test = q.dtest;
    assign o_fault = q.fault;
    assign o_ls_fault = q.ls_fault;

endmodule // sag_top

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import sag_pkg::*;
    localparam int unsigned DG = 4;
    localparam int unsigned STR = 50;
    localparam int unsigned FC = 20;
    localparam logic [15:0] SBL_CMD [9] = '{16'hc000, 16'hd300, 16'hc0ff, 16'h40ff,
        16'hd200, 16'h9200, 16'h9000, 16'hd300, 16'h0000};
    localparam logic [8:0] SBL_EXP = 9'b010101110;
    logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_serial_mode = 1'b0, i_fire_permit = 1'b1;
    logic i_cmd_valid = 1'b0, i_deploy_valid = 1'b0, i_idle_valid = 1'b0, i_diag_start = 1'b0;
    logic i_diag_mos_en = 1'b0, i_diag_fault = 1'b0, i_mos_ok = 1'b0, i_fault_clear = 1'b0;
    logic [7:0] i_gnd_loss = 8'h00, i_deploy_ch = 8'h00, i_idle_ch = 8'h00;
    logic [15:0] i_cmd_word = 16'h0000;
    wire logic i_enable_in_ch01, i_enable_in_ch23, i_enable_in_ch45, i_enable_in_ch67, pin67;
    logic o_serial_enable_dout, o_serial_enable_dout_oe_n, o_sbl_active, o_diag_busy;
    logic [1:0] o_mode;
    logic [2:0] o_diag_ch;
    sag_diag_test_t o_diag_test;
    logic [7:0] o_fault, o_ls_fault, o_window, o_firing, o_high_side_switch, o_low_side_switch;
    integer failures = 0, n_compared = 0, cycles = 0, seed = 32'hf73ab222;

    sag_top #(.DEGLITCH_CYC(DG), .STRETCH_CYC(STR), .FIRE_CYC(FC), .DIAG_STEP_CYC(10)) dut (.*);
    sag_arm_link_model link (.i_dout(i_enable_in_ch67), .o_din(i_enable_in_ch01),
        .o_sel(i_enable_in_ch23), .o_sclk(i_enable_in_ch45), .o_pin67(pin67));
    assign i_enable_in_ch67 = o_serial_enable_dout_oe_n ? pin67 : o_serial_enable_dout;

    always #5 i_ref_clk = ~i_ref_clk;

    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic done(input string nm);
        $display("test %s ended, mismatches %0d", nm, failures);
    endtask

    // Kinds: 0 deploy, 1 idle, 2 command word, 3 diagnostic start, 4 fault clear.
    task automatic pulse(input int kind, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_deploy_ch <= v[7:0];
        i_idle_ch <= v[7:0];
        i_cmd_word <= v;
        {i_deploy_valid, i_idle_valid, i_cmd_valid} <= {kind == 0, kind == 1, kind == 2};
        {i_diag_start, i_fault_clear} <= {kind == 3, kind == 4};
        @(posedge i_ref_clk);
        {i_deploy_valid, i_idle_valid, i_cmd_valid, i_diag_start, i_fault_clear} <= 5'h00;
    endtask

    task automatic wait_idle(output logic moved);
        moved = 1'b0;
        tick(2);
        for (int n = 0; n < 4000 && o_diag_busy !== 1'b0; n++) begin
            if (o_diag_test !== SAG_DT_BATT) moved = 1'b1;
            tick(1);
        end
        check(16'(o_diag_busy), 16'h0000);
    endtask

    function automatic logic [7:0] arm_mask(input logic [3:0] wd);
        for (int p = 0; p < 4; p++) arm_mask[2 * p +: 2] = {2{wd[3 - p]}};
    endfunction

    initial begin : main
        logic [3:0] wa, wb;
        logic [7:0] m;
        logic seen;
        int e;
        tick(5);
        i_rstn <= 1'b1;
        tick(3);
        check(16'(o_mode), 16'h0003);
        check({o_window, o_firing}, 16'h0000);
        check(16'(o_sbl_active), 16'h0000);
        done("reset");
        m = 8'h01 << 3'($random(seed));
        pulse(0, 16'(m));
        tick(1);
        check(16'(o_window), 16'(m));
        tick(30);
        check(16'(o_firing), 16'h0000);
        pulse(0, 16'(m));
        tick(STR - 25);
        check(16'(o_window), 16'h0000);
        pulse(0, 16'h00ff);
        pulse(1, 16'h00ff);
        tick(2);
        check(16'(o_window), 16'h0000);
        done("spi_timer");
        wa = 4'h8 >> 2'($random(seed));
        m = arm_mask(wa);
        link.set_pins(wa);
        tick(DG + 8);
        check(16'(o_window), 16'(m));
        link.set_pins(4'h0);
        tick(DG + 8);
        pulse(1, 16'h00ff);
        tick(2);
        check(16'(o_window), 16'(m));
        pulse(0, 16'(m & 8'h55));
        tick(3);
        check({o_firing, o_high_side_switch}, {2{m & 8'h55}});
        pulse(1, 16'h00ff);
        tick(1);
        check(16'(o_firing), 16'(m & 8'h55));
        tick(FC);
        check({o_firing, o_high_side_switch}, 16'h0000);
        tick(STR);
        done("discrete");
        i_fire_permit <= 1'b0;
        tick(4);
        link.set_pins(wa);
        tick(DG + 8);
        pulse(0, 16'(m));
        tick(3);
        check(16'(o_firing), 16'h0000);
        link.set_pins(4'h0);
        i_fire_permit <= 1'b1;
        tick(STR + DG + 10);
        done("permit");
        i_serial_mode <= 1'b1;
        tick(4);
        for (int k = 0; k < 3; k++) begin
            wa = 4'($random(seed));
            wb = 4'($random(seed));
            e = (k == 2) ? 2 : 4 * k + 3;
            link.send({wa, wb}, e, seen);
            tick(DG + 8);
            check(16'(o_window), 16'((e == 2) ? 8'h00 : arm_mask(wb)));
            if (e != 2) check(16'(seen), 16'(wb[3]));
            tick(STR + 5);
        end
        i_serial_mode <= 1'b0;
        link.set_pins(4'h0);
        done("serial");
        for (int k = 0; k < 9; k++) begin
            pulse(2, SBL_CMD[k]);
            tick(1);
            check(16'(o_sbl_active), 16'(SBL_EXP[k]));
        end
        done("loop_test");
        i_fire_permit <= 1'b0;
        i_diag_mos_en <= 1'b1;
        tick(4);
        pulse(3, 16'h0000);
        wait_idle(seen);
        check({o_ls_fault, o_fault}, 16'hffff);
        check(16'(o_diag_ch), 16'h0007);
        check(16'(seen), 16'h0001);
        pulse(4, 16'h0000);
        i_fire_permit <= 1'b1;
        i_diag_mos_en <= 1'b0;
        i_diag_fault <= 1'b1;
        i_gnd_loss <= 8'h08;
        tick(1);
        check({o_ls_fault, o_fault}, 16'h0000);
        pulse(3, 16'h0000);
        wait_idle(seen);
        check({o_ls_fault, o_fault}, 16'h00f7);
        check(16'(seen), 16'h0000);
        done("diagnostic");
        close_out();
    end
endmodule // tb_top

`default_nettype wire
